// ===== core/poe_pkg.sv
// Constants, field positions and types of the output-stop request logic.
// Assumes a single 10 MHz clock and an AXI4-Lite register port.
package poe_pkg;

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_REQ_A  = 8'h00; // request_input_8_control_status
	localparam logic [7:0] OFS_REQ_B  = 8'h04; // request_input_10_control_status
	localparam logic [7:0] OFS_REQ_C  = 8'h08; // request_input_11_control_status
	localparam logic [7:0] OFS_REQ_D  = 8'h0c; // request_input_12_control_status
	localparam logic [7:0] OFS_OSC    = 8'h10; // oscillation_stop_control_status
	localparam logic [7:0] OFS_SW     = 8'h14; // software_output_disable
	localparam logic [7:0] OFS_STATUS = 8'h18; // sticky event flags, write one to clear
	localparam logic [7:0] OFS_MASK   = 8'h1c; // interrupt mask
	localparam logic [7:0] OFS_ADD    = 8'h20; // extra disabling conditions

	// ----------------------------------------------------------------
	// Register select codes
	// ----------------------------------------------------------------
	localparam logic [3:0] SEL_OSC    = 4'h4;
	localparam logic [3:0] SEL_SW     = 4'h5;
	localparam logic [3:0] SEL_STATUS = 4'h6;
	localparam logic [3:0] SEL_MASK   = 4'h7;
	localparam logic [3:0] SEL_ADD    = 4'h8;
	localparam logic [3:0] SEL_NONE   = 4'hf;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int MODE_LSB   = 0;  // request_x_accept_mode[1:0]
	localparam int ENABLE_BIT = 8;  // request_x_disable_enable, osc_stop_disable_enable
	localparam int FLAG_BIT   = 12; // request_x_flag, osc_stop_detect_flag
	localparam int SW_CH34    = 0;  // sw_disable_timer_ch3_ch4
	localparam int SW_CH67    = 1;  // sw_disable_timer_ch6_ch7
	localparam int SW_CH0     = 2;  // sw_disable_timer_ch0
	localparam int SW_PWM02   = 3;  // sw_disable_pwm_ch0_to_2
	localparam int SW_PWM03   = 4;  // sw_disable_pwm_ch0_to_3
	localparam int ST_OSC_BIT = 4;  // status bit of the oscillation stop event
	localparam int ADD_A_BIT  = 0;  // request_a_add_to_ch3_ch4

	// ----------------------------------------------------------------
	// Counts, reset values and encodings
	// ----------------------------------------------------------------
	localparam int          REQ_N         = 4;
	localparam int unsigned DIV_LO        = 8;
	localparam int unsigned DIV_MID       = 16;
	localparam int unsigned DIV_HI        = 128;
	localparam logic [4:0]  LEVEL_SAMPLES = 5'h10;
	localparam logic [4:0]  RST_SW        = 5'h00;
	localparam logic [4:0]  RST_MASK      = 5'h00;
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;

	typedef enum logic [1:0] {
		MODE_EDGE   = 2'b00,
		MODE_DIV8   = 2'b01,
		MODE_DIV16  = 2'b10,
		MODE_DIV128 = 2'b11
	} accept_mode_e;

endpackage : poe_pkg

// ===== core/sample_tick_if.sv
// Sample enables from the clock divider to the request filters.
// Assumes producer and consumers share aclk.
`timescale 1ns/100ps
interface sample_tick_if;
	logic tick_div8;   // One-cycle pulse every 8 clocks
	logic tick_div16;  // One-cycle pulse every 16 clocks
	logic tick_div128; // One-cycle pulse every 128 clocks

	modport src (output tick_div8, output tick_div16, output tick_div128);
	modport snk (input tick_div8, input tick_div16, input tick_div128);
endinterface : sample_tick_if

// ===== core/sample_divider.sv
// Divider making the PCLK/8, /16 and /128 sample enables.
// Assumes one clock; ticks are aligned so /128 implies /16 implies /8.
`timescale 1ns/100ps
module sample_divider (
	input wire logic     aclk,    // Peripheral clock
	input wire logic     aresetn, // Synchronous reset, active low
	sample_tick_if.src   ticks    // Sample enables out
);
	typedef struct packed {
		logic [6:0] cnt;
		logic       t8;
		logic       t16;
		logic       t128;
	} div_s;

	div_s s;
	div_s next_s;

	// Divider position that ends one period
	function automatic logic hit(input logic [6:0] c, input int unsigned d);
		return ((32'(c) % d) == (d - 32'd1));
	endfunction : hit

	// Free-running count and registered ticks
	always_comb
	begin
		next_s      = s;
		next_s.cnt  = s.cnt + 7'h01;
		next_s.t8   = hit(s.cnt, poe_pkg::DIV_LO);
		next_s.t16  = hit(s.cnt, poe_pkg::DIV_MID);
		next_s.t128 = hit(s.cnt, poe_pkg::DIV_HI);
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			s <= '0;
		else
			s <= next_s;
	end

	assign ticks.tick_div8   = s.t8;
	assign ticks.tick_div16  = s.t16;
	assign ticks.tick_div128 = s.t128;

	chk_tick8_period: assert property (@(posedge aclk) disable iff (!aresetn)
		s.t8 |=> !s.t8 [*7] ##1 s.t8)
		else $error("divide-by-8 tick period wrong");
	chk_tick16_nest: assert property (@(posedge aclk) disable iff (!aresetn)
		s.t16 |-> s.t8 ##8 (s.t8 && !s.t16))
		else $error("divide-by-16 tick not on alternate /8 ticks");
	chk_tick128_nest: assert property (@(posedge aclk) disable iff (!aresetn)
		s.t128 |-> s.t16)
		else $error("divide-by-128 tick off the /16 grid");
endmodule : sample_divider

// ===== core/request_filter.sv
// Acceptance filter for one active-low output-stop request pin.
// Assumes the pin is asynchronous and the ticks come from sample_divider.
`timescale 1ns/100ps
module request_filter (
	input wire logic       aclk,    // Peripheral clock
	input wire logic       aresetn, // Synchronous reset, active low
	input wire logic       pin_n,   // Request pin, active low, asynchronous
	input wire logic [1:0] mode,    // Acceptance mode
	sample_tick_if.snk     ticks,   // Sample enables
	output logic           accept   // One-cycle pulse per accepted request
);
	typedef struct packed {
		logic [1:0] sync;
		logic       prev;
		logic [4:0] cnt;
		logic       accept;
	} filt_s;

	filt_s s;
	filt_s next_s;
	logic  tick;

	// Edge or sampled-level acceptance
	always_comb
	begin
		next_s        = s;
		next_s.sync   = {s.sync[0], pin_n};
		next_s.prev   = s.sync[1];
		next_s.accept = 1'b0;
		case (mode)
			poe_pkg::MODE_EDGE:   tick = 1'b0;
			poe_pkg::MODE_DIV8:   tick = ticks.tick_div8;
			poe_pkg::MODE_DIV16:  tick = ticks.tick_div16;
			poe_pkg::MODE_DIV128: tick = ticks.tick_div128;
			default:              tick = 1'b0;
		endcase
		if (mode == poe_pkg::MODE_EDGE)
		begin
			next_s.cnt    = 5'h00;
			next_s.accept = s.prev & ~s.sync[1];
		end
		else if (tick)
		begin
			if (s.sync[1])
				next_s.cnt = 5'h00; // High sample breaks the run
			else if (s.cnt < poe_pkg::LEVEL_SAMPLES)
			begin
				next_s.cnt    = s.cnt + 5'h01;
				next_s.accept = (s.cnt == poe_pkg::LEVEL_SAMPLES - 5'h01);
			end
		end
	end

	// Pin idles high, so reset assumes high
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			s <= '{sync: 2'h3, prev: 1'b1, cnt: 5'h00, accept: 1'b0};
		else
			s <= next_s;
	end

	assign accept = s.accept;

	chk_edge_accept: assert property (@(posedge aclk) disable iff (!aresetn)
		(mode == poe_pkg::MODE_EDGE && s.prev && !s.sync[1]) |=> s.accept)
		else $error("falling edge not accepted");
	chk_level_count: assert property (@(posedge aclk) disable iff (!aresetn)
		($past(mode) != poe_pkg::MODE_EDGE && s.accept) |-> ($past(s.cnt) == 5'h0f
			&& s.cnt == 5'h10))
		else $error("level accept without sixteen low samples");
	chk_level_break: assert property (@(posedge aclk) disable iff (!aresetn)
		(mode != poe_pkg::MODE_EDGE && tick && s.sync[1]) |=> (s.cnt == 5'h00 && !s.accept))
		else $error("high sample did not restart the count");
endmodule : request_filter

// ===== core/output_stop_ctrl.sv
// Output-stop request logic: four filtered request pins, oscillation stop,
// software forcing, AXI4-Lite registers and one level interrupt.
// Assumes one 10 MHz clock; request pins and the oscillation stop level are
// asynchronous and pass two flip-flops before use.
//
// The AXI4-Lite interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/100ps
module output_stop_ctrl (
	input  wire logic        aclk,                    // Peripheral clock, 10 MHz
	input  wire logic        aresetn,                 // Synchronous reset, active low
	input  wire logic [7:0]  awaddr,                  // Write address
	input  wire logic        awvalid,                 // Write address valid
	output logic             awready,                 // Write address ready
	input  wire logic [31:0] wdata,                   // Write data
	input  wire logic [3:0]  wstrb,                   // Write byte strobes
	input  wire logic        wvalid,                  // Write data valid
	output logic             wready,                  // Write data ready
	output logic [1:0]       bresp,                   // Write response
	output logic             bvalid,                  // Write response valid
	input  wire logic        bready,                  // Write response ready
	input  wire logic [7:0]  araddr,                  // Read address
	input  wire logic        arvalid,                 // Read address valid
	output logic             arready,                 // Read address ready
	output logic [31:0]      rdata,                   // Read data
	output logic [1:0]       rresp,                   // Read response
	output logic             rvalid,                  // Read data valid
	input  wire logic        rready,                  // Read data ready
	input  wire logic        fault_request_pin_a_n,   // Request pin a, active low
	input  wire logic        fault_request_pin_b_n,   // Request pin b, active low
	input  wire logic        fault_request_pin_c_n,   // Request pin c, active low
	input  wire logic        fault_request_pin_d_n,   // Request pin d, active low
	input  wire logic        osc_stop_detect,         // Clock monitor stop level
	output logic             disable_timer_ch3_ch4,   // Force timer ch3/ch4 outputs off
	output logic             disable_timer_ch6_ch7,   // Force timer ch6/ch7 outputs off
	output logic             disable_timer_ch0,       // Force timer ch0 outputs off
	output logic             disable_pwm_ch0_to_2,    // Force pwm ch0-2 outputs off
	output logic             disable_pwm_ch0_to_3,    // Force pwm ch0-3 outputs off
	output logic             irq                      // Level interrupt, active high
);
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic        aw_got;
		logic        w_got;
		logic [7:0]  waddr;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        rvalid;
		logic [1:0]  rresp;
		logic [31:0] rdata;
		logic [3:0][1:0] mode;
		logic [3:0]  en;
		logic [3:0]  flag;
		logic [1:0]  osc_sync;
		logic        osc_prev;
		logic        osc_en;
		logic        osc_flag;
		logic [4:0]  sw;
		logic [4:0]  mask;
		logic        add_a;
		logic [4:0]  dis;
		logic        irq;
	} ctrl_s;

	ctrl_s      s;
	ctrl_s      next_s;
	logic [3:0] pins_n;
	logic [3:0] acc;

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Address to register select; unaligned or unknown gives SEL_NONE
	function automatic logic [3:0] reg_sel(input logic [7:0] a);
		case (a)
			poe_pkg::OFS_REQ_A:  return 4'h0;
			poe_pkg::OFS_REQ_B:  return 4'h1;
			poe_pkg::OFS_REQ_C:  return 4'h2;
			poe_pkg::OFS_REQ_D:  return 4'h3;
			poe_pkg::OFS_OSC:    return poe_pkg::SEL_OSC;
			poe_pkg::OFS_SW:     return poe_pkg::SEL_SW;
			poe_pkg::OFS_STATUS: return poe_pkg::SEL_STATUS;
			poe_pkg::OFS_MASK:   return poe_pkg::SEL_MASK;
			poe_pkg::OFS_ADD:    return poe_pkg::SEL_ADD;
			default:             return poe_pkg::SEL_NONE;
		endcase
	endfunction : reg_sel

	// Layout of a control/status word
	function automatic logic [15:0] ctrl_word(input logic [1:0] m, input logic e,
		input logic f);
		logic [15:0] w;
		w = 16'h0000;
		w[poe_pkg::MODE_LSB +: 2] = m;
		w[poe_pkg::ENABLE_BIT]    = e;
		w[poe_pkg::FLAG_BIT]      = f;
		return w;
	endfunction : ctrl_word

	// Byte-lane merge of a 16-bit register
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] d,
		input logic [1:0] st);
		return {st[1] ? d[15:8] : old[15:8], st[0] ? d[7:0] : old[7:0]};
	endfunction : merge16

	// ----------------------------------------------------------------
	// Request filters and sample divider
	// ----------------------------------------------------------------
	sample_tick_if ticks ();

	sample_divider u_div (
		.aclk    (aclk),
		.aresetn (aresetn),
		.ticks   (ticks.src)
	);

	assign pins_n = {fault_request_pin_d_n, fault_request_pin_c_n,
		fault_request_pin_b_n, fault_request_pin_a_n};

	// Pin a has no mode field and is edge accepted
	for (genvar k = 0; k < poe_pkg::REQ_N; k++)
	begin : g_filt
		request_filter u_filt (
			.aclk    (aclk),
			.aresetn (aresetn),
			.pin_n   (pins_n[k]),
			.mode    ((k == 0) ? poe_pkg::MODE_EDGE : s.mode[k]),
			.ticks   (ticks.snk),
			.accept  (acc[k])
		);
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb
	begin
		logic [3:0]  wsel;
		logic [3:0]  rsel;
		logic [4:0]  clr;
		logic [15:0] v;
		logic        osc_term;
		logic        req_ch34;
		wsel     = reg_sel(s.waddr);
		rsel     = reg_sel(araddr);
		clr      = 5'h00;
		v        = 16'h0000;
		osc_term = s.osc_flag & s.osc_en;
		req_ch34 = |(s.flag[3:1] & s.en[3:1]) | (s.flag[0] & s.add_a);
		next_s   = s;

		// Write address and data, in either order
		if (awvalid && awready)
		begin
			next_s.aw_got = 1'b1;
			next_s.waddr  = awaddr;
		end
		if (wvalid && wready)
		begin
			next_s.w_got = 1'b1;
			next_s.wdata = wdata;
			next_s.wstrb = wstrb;
		end

		// Commit a write once both halves are held
		if (s.aw_got && s.w_got && !s.bvalid)
		begin
			next_s.aw_got = 1'b0;
			next_s.w_got  = 1'b0;
			next_s.bvalid = 1'b1;
			next_s.bresp  = (wsel == poe_pkg::SEL_NONE) ? poe_pkg::RESP_SLVERR
				: poe_pkg::RESP_OKAY;
			if (wsel < 4'h4)
			begin
				v = merge16(ctrl_word(s.mode[wsel[1:0]], s.en[wsel[1:0]], s.flag[wsel[1:0]]),
					s.wdata[15:0], s.wstrb[1:0]);
				if (wsel != 4'h0)
					next_s.mode[wsel[1:0]] = v[poe_pkg::MODE_LSB +: 2];
				next_s.en[wsel[1:0]] = v[poe_pkg::ENABLE_BIT];
			end
			else
			begin
				case (wsel)
					poe_pkg::SEL_OSC:
					begin
						v = merge16(ctrl_word(2'h0, s.osc_en, s.osc_flag), s.wdata[15:0],
							s.wstrb[1:0]);
						next_s.osc_en = v[poe_pkg::ENABLE_BIT];
					end
					poe_pkg::SEL_SW:
						if (s.wstrb[0])
							next_s.sw = s.wdata[4:0];
					poe_pkg::SEL_STATUS:
						if (s.wstrb[0])
							clr = s.wdata[4:0];
					poe_pkg::SEL_MASK:
						if (s.wstrb[0])
							next_s.mask = s.wdata[4:0];
					poe_pkg::SEL_ADD:
						if (s.wstrb[0])
							next_s.add_a = s.wdata[poe_pkg::ADD_A_BIT];
					default:
						next_s.add_a = s.add_a;
				endcase
			end
		end
		if (s.bvalid && bready)
			next_s.bvalid = 1'b0;

		// Read: one cycle to the answer
		if (arvalid && arready)
		begin
			next_s.rvalid = 1'b1;
			next_s.rresp  = (rsel == poe_pkg::SEL_NONE) ? poe_pkg::RESP_SLVERR
				: poe_pkg::RESP_OKAY;
			case (rsel)
				4'h0, 4'h1, 4'h2, 4'h3:
					next_s.rdata = {16'h0000, ctrl_word(s.mode[rsel[1:0]], s.en[rsel[1:0]],
						s.flag[rsel[1:0]])};
				poe_pkg::SEL_OSC:
					next_s.rdata = {16'h0000, ctrl_word(2'h0, s.osc_en, s.osc_flag)};
				poe_pkg::SEL_SW:     next_s.rdata = {27'h0, s.sw};
				poe_pkg::SEL_STATUS: next_s.rdata = {27'h0, s.osc_flag, s.flag};
				poe_pkg::SEL_MASK:   next_s.rdata = {27'h0, s.mask};
				poe_pkg::SEL_ADD:    next_s.rdata = {31'h0, s.add_a};
				default:             next_s.rdata = 32'h0;
			endcase
		end
		if (s.rvalid && rready)
			next_s.rvalid = 1'b0;

		// Sticky flags; a new event wins over a clear
		next_s.flag     = (s.flag & ~clr[3:0]) | acc;
		next_s.osc_sync = {s.osc_sync[0], osc_stop_detect};
		next_s.osc_prev = s.osc_sync[1];
		next_s.osc_flag = (s.osc_flag & ~clr[poe_pkg::ST_OSC_BIT])
			| (s.osc_sync[1] & ~s.osc_prev);

		// Output disables from software, flags and oscillation stop
		next_s.dis[poe_pkg::SW_CH34]  = s.sw[poe_pkg::SW_CH34] | s.sw[poe_pkg::SW_PWM02]
			| req_ch34 | osc_term;
		next_s.dis[poe_pkg::SW_CH67]  = s.sw[poe_pkg::SW_CH67] | (s.flag[0] & s.en[0])
			| osc_term;
		next_s.dis[poe_pkg::SW_CH0]   = s.sw[poe_pkg::SW_CH0] | osc_term;
		next_s.dis[poe_pkg::SW_PWM02] = s.sw[poe_pkg::SW_PWM02] | s.sw[poe_pkg::SW_CH34]
			| osc_term;
		next_s.dis[poe_pkg::SW_PWM03] = s.sw[poe_pkg::SW_PWM03] | osc_term;
		next_s.irq = |({s.osc_flag, s.flag} & s.mask);
	end

	// ----------------------------------------------------------------
	// Registers and outputs
	// ----------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s      <= '0;
			s.sw   <= poe_pkg::RST_SW;
			s.mask <= poe_pkg::RST_MASK;
		end
		else
			s <= next_s;
	end

	assign awready               = !s.aw_got && !s.bvalid;
	assign wready                = !s.w_got && !s.bvalid;
	assign arready               = !s.rvalid;
	assign bvalid                = s.bvalid;
	assign bresp                 = s.bresp;
	assign rvalid                = s.rvalid;
	assign rresp                 = s.rresp;
	assign rdata                 = s.rdata;
	assign disable_timer_ch3_ch4 = s.dis[poe_pkg::SW_CH34];
	assign disable_timer_ch6_ch7 = s.dis[poe_pkg::SW_CH67];
	assign disable_timer_ch0     = s.dis[poe_pkg::SW_CH0];
	assign disable_pwm_ch0_to_2  = s.dis[poe_pkg::SW_PWM02];
	assign disable_pwm_ch0_to_3  = s.dis[poe_pkg::SW_PWM03];
	assign irq                   = s.irq;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	chk_flag_on_accept: assert property (@(posedge aclk) disable iff (!aresetn)
		(|acc) |=> ((s.flag & $past(acc)) == $past(acc)))
		else $error("accepted request did not set its flag");
	chk_irq_level: assert property (@(posedge aclk) disable iff (!aresetn)
		(|({s.osc_flag, s.flag} & s.mask)) |=> irq)
		else $error("unmasked flag did not raise the interrupt");
	chk_irq_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
		(({s.osc_flag, s.flag} & s.mask) == 5'h00) |=> !irq)
		else $error("interrupt raised with every flag masked");
	chk_flag_sticky: assert property (@(posedge aclk) disable iff (!aresetn)
		(s.flag[2] && !(s.aw_got && s.w_got && !s.bvalid)) |=> s.flag[2])
		else $error("request flag cleared itself");
	chk_req_disable: assert property (@(posedge aclk) disable iff (!aresetn)
		(s.flag[3] && s.en[3]) |=> disable_timer_ch3_ch4)
		else $error("enabled request flag did not disable ch3/ch4");
	chk_a_to_ch67: assert property (@(posedge aclk) disable iff (!aresetn)
		(s.flag[0] && s.en[0]) |=> disable_timer_ch6_ch7)
		else $error("enabled pin a flag did not disable ch6/ch7");
	chk_osc_flag_set: assert property (@(posedge aclk) disable iff (!aresetn)
		(s.osc_sync[1] && !s.osc_prev) |=> s.osc_flag)
		else $error("oscillation stop not flagged");
	chk_osc_disable: assert property (@(posedge aclk) disable iff (!aresetn)
		(s.osc_flag && s.osc_en) |=> (disable_timer_ch0 && disable_pwm_ch0_to_3
			&& disable_timer_ch6_ch7))
		else $error("oscillation stop did not disable outputs");
	chk_sw_ch34: assert property (@(posedge aclk) disable iff (!aresetn)
		s.sw[poe_pkg::SW_CH34] |=> (disable_timer_ch3_ch4 && disable_pwm_ch0_to_2))
		else $error("software ch3/ch4 force missing");
	chk_sw_pwm02: assert property (@(posedge aclk) disable iff (!aresetn)
		s.sw[poe_pkg::SW_PWM02] |=> (disable_timer_ch3_ch4 && disable_pwm_ch0_to_2))
		else $error("software pwm 0-2 force missing");
	chk_sw_ch67: assert property (@(posedge aclk) disable iff (!aresetn)
		s.sw[poe_pkg::SW_CH67] |=> disable_timer_ch6_ch7)
		else $error("software ch6/ch7 force missing");
	chk_sw_ch0: assert property (@(posedge aclk) disable iff (!aresetn)
		!disable_timer_ch0 |-> $past(!s.sw[poe_pkg::SW_CH0]))
		else $error("software ch0 force missing");
	chk_sw_pwm03: assert property (@(posedge aclk) disable iff (!aresetn)
		s.sw[poe_pkg::SW_PWM03] |=> disable_pwm_ch0_to_3)
		else $error("software pwm 0-3 force missing");
	chk_add_a_ch34: assert property (@(posedge aclk) disable iff (!aresetn)
		(s.flag[0] && s.add_a) |=> disable_timer_ch3_ch4)
		else $error("pin a flag not added to ch3/ch4");
endmodule : output_stop_ctrl

// ===== sim/fault_source.sv
// Far-side model: fault sources on the request pins and the oscillation monitor.
// Assumes it shares aclk with the block and drives just after the rising edge.
`timescale 1ns/100ps
module fault_source (
	input  wire logic  aclk,  // Peripheral clock
	output logic [3:0] pin_n, // Request pins a..d, active low, pulled up
	output logic       osc    // Oscillation stop level
);
	// ------------------------------------------------------------
	// Idle: pins released to their pull-up, clock running
	// ------------------------------------------------------------
	initial
	begin
		pin_n = 4'hf;
		osc = 1'b0;
	end

	// Low request held for a set number of clocks, then released
	task automatic pulse(input int i, input int n);
		@(posedge aclk);
		pin_n[i] <= 1'b0;
		repeat (n) @(posedge aclk);
		pin_n[i] <= 1'b1;
	endtask : pulse

	// Oscillation stop level change
	task automatic set_osc(input logic v);
		@(posedge aclk);
		osc <= v;
	endtask : set_osc
endmodule : fault_source

// ===== sim/output_stop_ctrl_tb_top.sv
// Self-checking bench for the output-stop request logic.
// Assumes the fault source model and a 10 MHz clock.
`timescale 1ns/100ps
module output_stop_ctrl_tb_top;
	typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] q; logic [1:0] r;
		logic [5:0] o;} row_s;
	logic        aclk, aresetn = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, irq;
	logic        arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid, arready, rvalid;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata, q;
	logic [3:0]  wstrb = 4'hf, pins;
	logic [1:0]  bresp, rresp, r;
	logic        osc_stop_detect, disable_timer_ch3_ch4, disable_timer_ch6_ch7;
	logic        disable_timer_ch0, disable_pwm_ch0_to_2, disable_pwm_ch0_to_3;
	int          mismatches = 0, tests_run = 0, d;
	row_s rows[8] = '{'{8'h14, 1, 1, 0, 6'h09}, '{8'h14, 8, 8, 0, 6'h09},
		'{8'h14, 2, 2, 0, 6'h02}, '{8'h14, 4, 4, 0, 6'h04}, '{8'h14, 16, 16, 0, 6'h10},
		'{8'h14, 0, 0, 0, 6'h00}, '{8'h24, 255, 0, 2, 6'h00}, '{8'h1c, 31, 31, 0, 6'h00}};

	// ------------------------------------------------------------
	// Clock, design, far side
	// ------------------------------------------------------------
	initial
	begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end
	output_stop_ctrl uut (.*, .fault_request_pin_a_n(pins[0]), .fault_request_pin_b_n(pins[1]),
		.fault_request_pin_c_n(pins[2]), .fault_request_pin_d_n(pins[3]));
	fault_source src (.aclk(aclk), .pin_n(pins), .osc(osc_stop_detect));

	// ------------------------------------------------------------
	// Bus cycles, compares, verdict
	// ------------------------------------------------------------
	task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] rs);
		logic aw, w;
		aw = 1'b1;
		w = 1'b1;
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (aw || w)
		begin
			@(posedge aclk);
			if (awready) aw = 1'b0;
			if (wready) w = 1'b0;
			awvalid <= aw;
			wvalid <= w;
		end
		bready <= 1'b1;
		do @(posedge aclk); while (!bvalid);
		rs = bresp;
		bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge aclk); while (!arready);
		arvalid <= 1'b0;
		rready <= 1'b1;
		do @(posedge aclk); while (!rvalid);
		v = rdata;
		rs = rresp;
		rready <= 1'b0;
	endtask : rd
	task automatic chk_val(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e)
		begin
			mismatches++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask : chk_val
	task automatic chk_out(input logic [5:0] e);
		chk_val(32'({irq, disable_pwm_ch0_to_3, disable_pwm_ch0_to_2, disable_timer_ch0,
			disable_timer_ch6_ch7, disable_timer_ch3_ch4}), 32'(e));
	endtask : chk_out
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] v;
		logic [1:0]  rs;
		rd(a, v, rs);
		chk_val(v, e);
	endtask : rd_chk
	task automatic report_and_stop();
		$display("tests_run=%0d mismatches=%0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : report_and_stop

	// Hang guard
	initial
	begin
		repeat (30000) @(posedge aclk);
		mismatches++;
		report_and_stop();
	end

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial
	begin
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd_chk(poe_pkg::OFS_SW, 32'(poe_pkg::RST_SW));
		rd_chk(poe_pkg::OFS_STATUS, 32'h0);
		foreach (rows[i])
		begin
			wr(rows[i].a, rows[i].d, r);
			chk_val(32'(r), 32'(rows[i].r));
			rd(rows[i].a, q, r);
			chk_val({q[29:0], r}, {rows[i].q[29:0], rows[i].r});
			repeat (2) @(posedge aclk);
			chk_out(rows[i].o);
		end
		for (int i = 0; i < 4; i++)
		begin
			wr(8'(4 * i), 32'h100, r);
			src.pulse(i, 3);
			repeat (6) @(posedge aclk);
			chk_out(i == 0 ? 6'h22 : 6'h21);
			rd_chk(8'(4 * i), 32'h1100);
			repeat (20) @(posedge aclk);
			chk_out(i == 0 ? 6'h22 : 6'h21);
			wr(poe_pkg::OFS_STATUS, 32'(1 << i), r);
			repeat (3) @(posedge aclk);
			chk_out(6'h00);
		end
		wr(8'h00, 32'h3, r);
		rd_chk(8'h00, 32'h0);
		wr(poe_pkg::OFS_ADD, 32'h1, r);
		src.pulse(0, 3);
		repeat (6) @(posedge aclk);
		chk_out(6'h21);
		wr(poe_pkg::OFS_STATUS, 32'h1, r);
		for (int m = 1; m < 4; m++)
		begin
			d = (m == 1) ? 8 : (m == 2) ? 16 : 128;
			wr(8'h0c, 32'h100 | 32'(m), r);
			src.pulse(3, 14 * d);
			repeat (2 * d) @(posedge aclk);
			chk_out(6'h00);
			src.pulse(3, 18 * d);
			repeat (6) @(posedge aclk);
			chk_out(6'h21);
			wr(poe_pkg::OFS_STATUS, 32'h8, r);
		end
		wr(poe_pkg::OFS_OSC, 32'h100, r);
		src.set_osc(1'b1);
		repeat (8) @(posedge aclk);
		chk_out(6'h3f);
		rd_chk(poe_pkg::OFS_OSC, 32'h1100);
		wr(poe_pkg::OFS_MASK, 32'h0, r);
		repeat (3) @(posedge aclk);
		chk_out(6'h1f);
		src.set_osc(1'b0);
		wr(poe_pkg::OFS_STATUS, 32'h10, r);
		repeat (3) @(posedge aclk);
		chk_out(6'h00);
		// Reset in mid-run drops forcing, flags and register contents
		wr(poe_pkg::OFS_SW, 32'h1f, r);
		src.pulse(1, 3);
		chk_out(6'h1f);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		chk_out(6'h00);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd_chk(poe_pkg::OFS_SW, 32'(poe_pkg::RST_SW));
		rd_chk(poe_pkg::OFS_STATUS, 32'h0);
		report_and_stop();
	end
endmodule : output_stop_ctrl_tb_top
